// ### siou_top.v
/*
 * Sixteen-in sixteen-out I/O unit: one I/O data word, direction,
 * polarity and control words, system status, clock source choice
 * and interrupts over a plain strobe register port.
 * Assumes a single 100 MHz clock; pins, peer mask and clock sense are
 * asynchronous and are synchronised here; the switch is caught once, unsynchronised.
 */
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "siou_defines.vh"

module siou_top #(
    parameter NPTS = 16
) (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire                    ce,
    input  wire [`SIOU_ADDR_W-1:0] reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata_r,
    input  wire [3:0]              addr_switch,
    input  wire [15:0]             peer_index_mask,
    input  wire                    servo_clk_in,
    input  wire                    phase_clk_in,
    input  wire [NPTS-1:0]         input_point,
    output reg  [NPTS-1:0]         output_point_r,
    output reg  [NPTS-1:0]         input_led_r,
    output reg  [NPTS-1:0]         output_led_r,
    output reg                     clk_source_r,
    output reg                     power_indicator_r,
    output reg                     irq_r
);

    // =================================================================
    // Declarations
    // =================================================================
    wire [NPTS-1:0]  in_sync;        // Debounced input points
    wire [15:0]      peer_sync;      // Synchronised peer index mask
    wire [1:0]       clk_sync;       // Synchronised clock senses
    reg  [31:0]      data_r;         // Written output drive bits
    reg  [31:0]      dir_r;          // Direction word
    reg  [31:0]      pol_r;          // Polarity word
    reg  [31:0]      ctrl_r;         // Control word
    reg  [4:0]       clksel_r;       // Clock source override
    reg  [3:0]       unit_index_r;   // Latched switch value
    reg              idx_valid_r;    // Switch has been captured
    reg  [`SIOU_IRQ_W-1:0] irq_stat_r; // Sticky event bits
    reg  [`SIOU_IRQ_W-1:0] irq_mask_r; // Event enables
    reg  [3:0]       err_code_r;     // Configuration error code
    reg              noclk_r;        // No-clock flag
    reg  [7:0]       noclk_cnt_r;    // Cycles without a clock edge
    reg  [1:0]       clk_prev_r;     // Previous clock senses
    reg  [NPTS-1:0]  in_prev_r;      // Previous input states
    reg  [31:0]      rd_nxt;         // Read mux
    wire [31:0]      pins_word;      // Sampled pins in word layout
    wire [31:0]      view_word;      // Data word as software sees it
    wire             overlap;        // Another unit shares our index
    wire             src_default;    // We hold the smallest index
    wire             src_sel;        // This unit sources clocks
    wire             clk_edge;       // Any clock toggled
    wire [`SIOU_IRQ_W-1:0] ev;       // Event pulses

    // =================================================================
    // Helpers
    // =================================================================
    // Address compare used by both decode paths
    function hit;
        input [`SIOU_ADDR_W-1:0] a;
        input [`SIOU_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Masked merge: take b where m is set, else a
    function [31:0] merge;
        input [31:0] a;
        input [31:0] b;
        input [31:0] m;
        begin
            merge = (a & ~m) | (b & m);
        end
    endfunction

    // =================================================================
    // Synchronisers
    // =================================================================
    siou_sync #(.W(NPTS)) u_in_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .din    (input_point),
        .dout_r (in_sync)
    );

    siou_sync #(.W(16)) u_peer_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .din    (peer_index_mask),
        .dout_r (peer_sync)
    );

    siou_sync #(.W(2)) u_clk_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .din    ({phase_clk_in, servo_clk_in}),
        .dout_r (clk_sync)
    );

    // =================================================================
    // Switch capture
    // =================================================================
    // Switch is a strap: caught once after reset release, not under it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_index_r <= 4'h0;
            idx_valid_r  <= 1'b0;
        end else if (ce && !idx_valid_r) begin
            unit_index_r <= addr_switch;
            idx_valid_r  <= 1'b1;
        end
    end

    // =================================================================
    // System status
    // =================================================================
    // Peer mask bit n is high when some other unit claims index n
    assign overlap = idx_valid_r & peer_sync[unit_index_r];

    // Default source: no peer holds a smaller index
    assign src_default = ((peer_sync & ((16'h0001 << unit_index_r)
                          - 16'h0001)) == 16'h0000);
    assign src_sel = clksel_r[`SIOU_CLKSEL_EN_BIT] ?
                     (clksel_r[3:0] == unit_index_r) : src_default;

    assign clk_edge = |(clk_sync ^ clk_prev_r);

    // Error code and no-clock watchdog; a non-source unit whose
    // clock stays still is taken as a source outside the CPU rack
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_code_r   <= `SIOU_ERR_NONE;
            noclk_r      <= 1'b0;
            noclk_cnt_r  <= 8'h00;
            clk_prev_r   <= 2'b00;
            clk_source_r <= 1'b0;
        end else if (ce) begin
            clk_prev_r   <= clk_sync;
            clk_source_r <= idx_valid_r & src_sel;
            err_code_r   <= overlap ? `SIOU_ERR_OVERLAP
                                    : `SIOU_ERR_NONE;
            if (clk_edge || clk_source_r) begin
                noclk_cnt_r <= 8'h00;
                noclk_r     <= 1'b0;
            end else if (noclk_cnt_r == `SIOU_NOCLK_LIMIT) begin
                noclk_r     <= 1'b1;
            end else begin
                noclk_cnt_r <= noclk_cnt_r + 8'h01;
            end
        end
    end

    // =================================================================
    // Data word
    // =================================================================
    // Inputs low half, outputs high half, polarity applied on read of direction-zero bits only
    assign pins_word = {output_point_r, in_sync};
    assign view_word = merge(pins_word ^ pol_r, data_r, dir_r);

    assign ev[`SIOU_IRQ_OVERLAP] = overlap & (err_code_r != `SIOU_ERR_OVERLAP);
    assign ev[`SIOU_IRQ_NOCLK]   = ~noclk_r & ~clk_edge & ~clk_source_r
                                   & (noclk_cnt_r == `SIOU_NOCLK_LIMIT);
    assign ev[`SIOU_IRQ_INCHG]   = |(in_sync ^ in_prev_r);

    // =================================================================
    // Register writes
    // =================================================================
    // Only direction-one bits take written data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_r     <= `SIOU_ZERO32;
            dir_r      <= `SIOU_DIR_RST;
            pol_r      <= `SIOU_POL_RST;
            ctrl_r     <= `SIOU_CTRL_RST;
            clksel_r   <= 5'h00;
            irq_mask_r <= {`SIOU_IRQ_W{1'b0}};
            irq_stat_r <= {`SIOU_IRQ_W{1'b0}};
            in_prev_r  <= {NPTS{1'b0}};
        end else if (ce) begin
            in_prev_r <= in_sync;
            if (reg_wr) begin
                if (hit(reg_addr, `SIOU_OFS_DATA)) begin
                    data_r <= merge(data_r, reg_wdata, dir_r);
                end else if (hit(reg_addr, `SIOU_OFS_DIR)) begin
                    dir_r <= reg_wdata;
                end else if (hit(reg_addr, `SIOU_OFS_POL)) begin
                    pol_r <= reg_wdata;
                end else if (hit(reg_addr, `SIOU_OFS_CTRL)) begin
                    ctrl_r <= reg_wdata;
                end else if (hit(reg_addr, `SIOU_OFS_CLKSEL)) begin
                    clksel_r <= reg_wdata[4:0];
                end else if (hit(reg_addr, `SIOU_OFS_IRQMASK)) begin
                    irq_mask_r <= reg_wdata[`SIOU_IRQ_W-1:0];
                end
            end
            // Set wins over a same-cycle write-one clear
            if (reg_wr && hit(reg_addr, `SIOU_OFS_IRQSTAT)) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata[`SIOU_IRQ_W-1:0])
                              | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
        end
    end

    // =================================================================
    // Read path
    // =================================================================
    // Unmapped addresses read as zero
    always @* begin
        rd_nxt = `SIOU_ZERO32;
        if (hit(reg_addr, `SIOU_OFS_DATA)) begin
            rd_nxt = view_word;
        end else if (hit(reg_addr, `SIOU_OFS_DIR)) begin
            rd_nxt = dir_r;
        end else if (hit(reg_addr, `SIOU_OFS_POL)) begin
            rd_nxt = pol_r;
        end else if (hit(reg_addr, `SIOU_OFS_CTRL)) begin
            rd_nxt = ctrl_r;
        end else if (hit(reg_addr, `SIOU_OFS_SYSSTAT)) begin
            rd_nxt[`SIOU_ERR_MSB:`SIOU_ERR_LSB] = err_code_r;
            rd_nxt[`SIOU_NOCLK_BIT] = noclk_r;
            rd_nxt[`SIOU_SRC_BIT]   = clk_source_r;
        end else if (hit(reg_addr, `SIOU_OFS_IRQSTAT)) begin
            rd_nxt[`SIOU_IRQ_W-1:0] = irq_stat_r;
        end else if (hit(reg_addr, `SIOU_OFS_IRQMASK)) begin
            rd_nxt[`SIOU_IRQ_W-1:0] = irq_mask_r;
        end else if (hit(reg_addr, `SIOU_OFS_CLKSEL)) begin
            rd_nxt[4:0] = clksel_r;
        end else if (hit(reg_addr, `SIOU_OFS_UNITIDX)) begin
            rd_nxt[3:0] = unit_index_r;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    // Read data stands one cycle only; pins and lamps are registered
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r       <= `SIOU_ZERO32;
            output_point_r    <= {NPTS{1'b0}};
            input_led_r       <= {NPTS{1'b0}};
            output_led_r      <= {NPTS{1'b0}};
            power_indicator_r <= 1'b0;
            irq_r             <= 1'b0;
        end else if (ce) begin
            reg_rdata_r    <= reg_rd ? rd_nxt : `SIOU_ZERO32;
            // Undriven output bits stay off; polarity flips the drive
            output_point_r <= (data_r[`SIOU_OUT_MSB:`SIOU_OUT_LSB]
                               ^ pol_r[`SIOU_OUT_MSB:`SIOU_OUT_LSB])
                              & dir_r[`SIOU_OUT_MSB:`SIOU_OUT_LSB];
            input_led_r    <= in_sync;
            output_led_r   <= output_point_r;
            power_indicator_r <= 1'b1;
            irq_r          <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule // siou_top

// ### siou_defines.vh
/*
 * Shared constants of the sixteen-in sixteen-out I/O unit: register
 * offsets, reset values, field positions and status codes.
 * Assumes inclusion by bare name from each design file.
 */
`ifndef SIOU_DEFINES_VH
`define SIOU_DEFINES_VH

// =====================================================================
// Register offsets (byte addresses, one aligned word each)
// =====================================================================
`define SIOU_ADDR_W          8
`define SIOU_OFS_DATA        8'h00
`define SIOU_OFS_DIR         8'h04
`define SIOU_OFS_POL         8'h08
`define SIOU_OFS_CTRL        8'h0C
`define SIOU_OFS_SYSSTAT     8'h10
`define SIOU_OFS_IRQSTAT     8'h14
`define SIOU_OFS_IRQMASK     8'h18
`define SIOU_OFS_CLKSEL      8'h1C
`define SIOU_OFS_UNITIDX     8'h20

// =====================================================================
// Reset values
// =====================================================================
`define SIOU_DIR_RST         32'hFFFF0000
`define SIOU_POL_RST         32'h00000000
`define SIOU_CTRL_RST        32'h00000000
`define SIOU_ZERO32          32'h00000000

// =====================================================================
// Field layout
// =====================================================================
`define SIOU_IN_LSB          0
`define SIOU_IN_MSB          15
`define SIOU_OUT_LSB         16
`define SIOU_OUT_MSB         31
`define SIOU_ERR_LSB         0
`define SIOU_ERR_MSB         3
`define SIOU_NOCLK_BIT       4
`define SIOU_SRC_BIT         5
`define SIOU_CLKSEL_EN_BIT   4

// =====================================================================
// Status codes and interrupt bits
// =====================================================================
`define SIOU_ERR_NONE        4'h0
`define SIOU_ERR_OVERLAP     4'h7
`define SIOU_IRQ_W           3
`define SIOU_IRQ_OVERLAP     0
`define SIOU_IRQ_NOCLK       1
`define SIOU_IRQ_INCHG       2
`define SIOU_NOCLK_LIMIT     8'hFF

`endif

// ### siou_sync.v
/*
 * Three-stage input synchroniser for a bus of pins; a change is taken
 * only once the second and third stages agree.
 * Assumes pins are asynchronous to clk.
 */
`timescale 1ns/1ps
`include "siou_defines.vh"

module siou_sync #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout_r
);

    // =================================================================
    // Stages
    // =================================================================
    reg [W-1:0] s1_r;   // Metastable stage, read only by s2
    reg [W-1:0] s2_r;   // Second stage
    reg [W-1:0] s3_r;   // Third stage

    // Shift and filter: per bit, update only where s2 and s3 agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= {W{1'b0}};
            s2_r   <= {W{1'b0}};
            s3_r   <= {W{1'b0}};
            dout_r <= {W{1'b0}};
        end else if (ce) begin
            s1_r   <= din;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            dout_r <= (s2_r & s3_r) | (dout_r & (s2_r | s3_r));
        end
    end

endmodule // siou_sync

// ### siou_top_sva.sv
/* Port-level checker for siou_top: read port, output drive, lamps.
   Assumes one clock clk and async active-low reset rst_n. */
`timescale 1ns/1ps
`include "siou_defines.vh"
module siou_chk #(
    parameter NPTS = 16
) (
    input wire                    clk,
    input wire                    rst_n,
    input wire                    ce,
    input wire [`SIOU_ADDR_W-1:0] reg_addr,
    input wire [31:0]             reg_wdata,
    input wire                    reg_wr,
    input wire                    reg_rd,
    input wire [31:0]             reg_rdata_r,
    input wire [3:0]              addr_switch,
    input wire [NPTS-1:0]         input_point,
    input wire [NPTS-1:0]         output_point_r,
    input wire [NPTS-1:0]         input_led_r,
    input wire [NPTS-1:0]         output_led_r,
    input wire                    irq_r
);
    // ================================================================
    // Mirrors of the written words, to predict the output drive
    // ================================================================
    reg [31:0] dir_m;   // Direction as written
    reg [31:0] pol_m;   // Polarity as written
    reg [31:0] data_m;  // Data word; only direction-one bits take writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_m  <= `SIOU_DIR_RST;
            pol_m  <= `SIOU_POL_RST;
            data_m <= `SIOU_ZERO32;
        end else if (reg_wr && ce) begin
            if (reg_addr == `SIOU_OFS_DIR)
                dir_m <= reg_wdata;
            if (reg_addr == `SIOU_OFS_POL)
                pol_m <= reg_wdata;
            if (reg_addr == `SIOU_OFS_DATA)
                data_m <= (data_m & ~dir_m) | (reg_wdata & dir_m);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ================================================================
    // Properties
    // ================================================================
    sequence s_cfg_rd;
        reg_rd && ce && (reg_addr == `SIOU_OFS_DIR ||
                         reg_addr == `SIOU_OFS_POL);
    endsequence
    sequence s_idx_rd;
        reg_rd && ce && reg_addr == `SIOU_OFS_UNITIDX;
    endsequence
    a_cfg_readback: assert property (s_cfg_rd |=> reg_rdata_r ==
        $past(reg_addr == `SIOU_OFS_DIR ? dir_m : pol_m))
        else $error("config word read back wrong");
    a_idx_switch: assert property (s_idx_rd |=>
        reg_rdata_r == {28'h0000000, $past(addr_switch)})
        else $error("unit index read differs from switch");
    a_rd_idle_zero: assert property (!$past(reg_rd) |->
        reg_rdata_r == 32'h00000000)
        else $error("read data outside its one cycle");
    a_out_drive: assert property ($past(ce) |-> output_point_r ==
        $past((data_m[31:16] ^ pol_m[31:16]) & dir_m[31:16]))
        else $error("output drive differs from written data");
    a_out_cause: assert property (!$stable(output_point_r) |->
        $past(reg_wr, 2))
        else $error("output moved without a write");
    a_out_lamp: assert property ($past(ce) |->
        output_led_r == $past(output_point_r))
        else $error("output lamp does not follow drive");
    a_in_lamp: assert property ($stable(input_point) [*8] |->
        input_led_r == input_point)
        else $error("input lamp does not follow contact");
    a_irq_drop: assert property ($fell(irq_r) |->
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped without a write");
endmodule // siou_chk

bind siou_top siou_chk #(.NPTS(NPTS)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .addr_switch(addr_switch),
    .input_point(input_point), .output_point_r(output_point_r),
    .input_led_r(input_led_r), .output_led_r(output_led_r),
    .irq_r(irq_r));

// ### siou_peer_model.sv
/* Model of the clock-source peer on the unit bus.
   Assumes clk of the bench; clocks stand still while not running. */
`timescale 1ns/1ps
module siou_peer_model (
    input  wire clk,
    input  wire clk_on,
    input  wire uut_src,
    output reg  servo_clk,
    output reg  phase_clk
);
    reg [3:0] cnt_r;  // Divider; phase runs four times slower
    initial begin
        servo_clk = 1'b0;
        phase_clk = 1'b0;
        cnt_r     = 4'h0;
    end
    // Peer drives only while the unit under test is not the source
    always @(posedge clk) begin
        if (clk_on && !uut_src) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r[1:0] == 2'h3)
                servo_clk <= ~servo_clk;
            if (cnt_r == 4'hF)
                phase_clk <= ~phase_clk;
        end
    end
endmodule // siou_peer_model

// ### tb_top.sv
/* Self-checking bench for siou_top over its strobe register port.
   Assumes switch strapped to 5 and ce held high throughout. */
`timescale 1ns/1ps
`include "siou_defines.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
    n_fail = n_fail + 1; $display("[ERR] %0t got %h exp %h", $time, \
    g, e); end end
module tb_top;
    reg         clk, rst_n, ce, reg_wr, reg_rd, clk_on;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg  [3:0]  addr_switch;
    reg  [15:0] peer_index_mask, input_point;
    wire [31:0] reg_rdata_r;
    wire [15:0] output_point_r, input_led_r, output_led_r;
    wire        servo_clk_in, phase_clk_in, clk_source_r, irq_r;
    wire        power_indicator_r;
    integer     n_fail, checks;
    siou_top #(.NPTS(16)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .addr_switch(addr_switch), .peer_index_mask(peer_index_mask),
        .servo_clk_in(servo_clk_in), .phase_clk_in(phase_clk_in),
        .input_point(input_point), .output_point_r(output_point_r),
        .input_led_r(input_led_r), .output_led_r(output_led_r),
        .clk_source_r(clk_source_r),
        .power_indicator_r(power_indicator_r), .irq_r(irq_r));
    siou_peer_model u_peer (.clk(clk), .clk_on(clk_on),
        .uut_src(clk_source_r), .servo_clk(servo_clk_in),
        .phase_clk(phase_clk_in));
    // ================================================================
    // Clock, bus tasks, verdict
    // ================================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // One-cycle write strobe, released at the edge that takes it
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rdc(input [7:0] a, input [31:0] e);
        reg [31:0] d;
        begin
            @(posedge clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            d = reg_rdata_r;
            `CHK(d, e)
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Watchdog well beyond the roughly 430 cycles of the tests
    initial begin
        #50000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
    // ================================================================
    // Tests
    // ================================================================
    initial begin
        n_fail = 0;
        checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        {reg_wr, reg_rd, clk_on} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        addr_switch = 4'h5;
        peer_index_mask = 16'h0000;
        input_point = 16'h1234;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`SIOU_OFS_DIR, `SIOU_DIR_RST);
        rdc(`SIOU_OFS_POL, `SIOU_POL_RST);
        rdc(`SIOU_OFS_CTRL, `SIOU_CTRL_RST);
        rdc(`SIOU_OFS_UNITIDX, 32'h00000005);
        rdc(8'h24, 32'h00000000);
        rdc(`SIOU_OFS_DATA, 32'h00001234);
        `CHK(input_led_r, 16'h1234)
        `CHK(power_indicator_r, 1'b1)
        $display("test reset values done");
        wr(`SIOU_OFS_DATA, 32'hA5C3FFFF);
        wr(`SIOU_OFS_POL, 32'h00FF0001);
        tick(3);
        `CHK(output_point_r, 16'hA53C)
        `CHK(output_led_r, 16'hA53C)
        rdc(`SIOU_OFS_DATA, 32'hA5C31235);
        wr(`SIOU_OFS_DIR, 32'h00000000);
        tick(3);
        `CHK(output_point_r, 16'h0000)
        wr(`SIOU_OFS_DIR, `SIOU_DIR_RST);
        wr(`SIOU_OFS_POL, 32'h00000000);
        $display("test data word done");
        wr(`SIOU_OFS_IRQSTAT, 32'h00000007);
        @(posedge clk) peer_index_mask <= 16'h0020;
        tick(10);
        rdc(`SIOU_OFS_SYSSTAT, 32'h00000027);
        rdc(`SIOU_OFS_IRQSTAT, 32'h00000001);
        `CHK(irq_r, 1'b0)
        wr(`SIOU_OFS_IRQMASK, 32'h00000007);
        tick(3);
        `CHK(irq_r, 1'b1)
        wr(`SIOU_OFS_IRQSTAT, 32'h00000001);
        tick(3);
        `CHK(irq_r, 1'b0)
        @(posedge clk) peer_index_mask <= 16'h0004;
        tick(10);
        `CHK(clk_source_r, 1'b0)
        tick(300);
        rdc(`SIOU_OFS_SYSSTAT, 32'h00000010);
        rdc(`SIOU_OFS_IRQSTAT, 32'h00000002);
        $display("test status and interrupt done");
        @(posedge clk) clk_on <= 1'b1;
        tick(40);
        rdc(`SIOU_OFS_SYSSTAT, 32'h00000000);
        wr(`SIOU_OFS_CLKSEL, 32'h00000015);
        tick(3);
        `CHK(clk_source_r, 1'b1)
        rdc(`SIOU_OFS_SYSSTAT, 32'h00000020);
        wr(`SIOU_OFS_CLKSEL, 32'h00000013);
        tick(3);
        `CHK(clk_source_r, 1'b0)
        $display("test clock source done");
        tally_and_finish;
    end
endmodule // tb_top
